// *** core/spmsp_clkgen.sv ***
`timescale 1ns/100ps
module spmsp_clkgen (
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// rate request and half-period tick
	spmsp_rate_if.gen rif
);
	import spmsp_pkg::*;

	logic [3:0] cnt_reg;
	logic [3:0] term;
	logic       tick_reg;

	// one tick per half period of the serial clock
	always_comb begin
		case (rif.rate)
			SPMSP_RATE_0: term = 4'(SPMSP_DIV_0 / 2 - 1);
			SPMSP_RATE_1: term = 4'(SPMSP_DIV_1 / 2 - 1);
			SPMSP_RATE_2: term = 4'(SPMSP_DIV_2 / 2 - 1);
			SPMSP_RATE_3: term = 4'(SPMSP_DIV_3 / 2 - 1);
			default:      term = 4'(SPMSP_DIV_0 / 2 - 1);
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_reg  <= 4'h0;
			tick_reg <= 1'b0;
		end else if (!rif.run) begin
			cnt_reg  <= 4'h0;
			tick_reg <= 1'b0;
		end else if (cnt_reg >= term) begin
			cnt_reg  <= 4'h0;
			tick_reg <= 1'b1;
		end else begin
			cnt_reg  <= cnt_reg + 4'h1;
			tick_reg <= 1'b0;
		end
	end

	assign rif.tick = tick_reg;
endmodule

// *** core/spmsp_sync.sv ***
`timescale 1ns/100ps
module spmsp_sync #(
	parameter int            W       = 1,
	parameter logic [W-1:0]  RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule

// *** core/spmsp_top.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - master reads miso, slave drives miso; bytes travel msb first
// - slave releases miso while select is high, drives it while low
// - full duplex: received byte replaces sent byte, one done flag
// - slave with phase zero and select low refuses data writes
// - unselected slave ignores serial clock and mosi
// - master seeing select low drops master, port enable, sets fault
// - one byte is exchanged in exactly eight clock pulses
// - master clock from core clock via rate bits; unused as slave
// - both ends share polarity and phase; master clocks both lines
// - master data write loads shifter, starts clock, shifts out
// - after eight bits shifter copies to read buffer, read returns it
// - slave starts on select low plus clock, shifts both ways
// - each bit is driven half a cycle before its sampling edge
// - control, status and data registers at consecutive locations
// - control top bit enables the port interrupt
// - port enable hands the four pins to the serial function
// - rate codes divide core clock by 2, 4, 16, 32
// - polarity bit sets master idle clock level; the slave does not use it
// - each finished byte sets done flag, interrupt if enabled
module spmsp_top #(
	parameter int ADDR_W = spmsp_pkg::SPMSP_ADDR_W
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              nrst,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// serial pins
	input  wire logic              sck_in,
	output logic                   sck_out,
	output logic                   sck_oe_n,
	input  wire logic              mosi_in,
	output logic                   mosi_out,
	output logic                   mosi_oe_n,
	input  wire logic              miso_in,
	output logic                   miso_out,
	output logic                   miso_oe_n,
	input  wire logic              ss_n_in,
	// status to the system
	output logic                   irq,
	output logic                   pins_active
);
	import spmsp_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pins_s;
	logic       sck_s;
	logic       mosi_s;
	logic       miso_s;
	logic       ss_n_s;

	spmsp_sync #(.W(4), .RST_VAL(4'h1)) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.din   ({sck_in, mosi_in, miso_in, ss_n_in}),
		.dout  (pins_s)
	);
	assign {sck_s, mosi_s, miso_s, ss_n_s} = pins_s;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic       irq_en_reg;
	logic       port_en_reg;
	logic       master_reg;
	logic       clock_polarity_reg;
	logic       clock_phase_reg;
	spmsp_rate_t rate_reg;
	logic       done_reg;
	logic       write_collision_flag_reg;
	logic       mode_fault_flag_reg;
	logic       seen_done_reg;
	logic       seen_write_collision_flag_reg;
	logic       seen_mode_fault_flag_reg;
	logic [7:0] shreg_reg;
	logic [7:0] rdbuf_reg;
	logic       rx_bit_reg;
	logic       out_bit_reg;
	logic       busy_reg;
	logic [3:0] edge_cnt_reg;
	logic       sck_d_reg;
	logic       sck_reg;
	logic [31:0] prdata_reg;
	logic       pready_reg;
	logic       pslverr_reg;
	logic       sck_oe_n_reg;
	logic       mosi_oe_n_reg;
	logic       miso_oe_n_reg;
	logic       irq_reg;
	logic       pins_active_reg;
	logic [1:0] msamp_reg;
	logic [1:0] mfin_reg;
	logic [7:0] mrx_reg;

	spmsp_rate_if rif ();

	spmsp_clkgen u_clkgen (
		.clock (clock),
		.nrst  (nrst),
		.rif   (rif)
	);
	// the divider only runs for a master byte in flight
	assign rif.run  = busy_reg & master_reg;
	assign rif.rate = rate_reg;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic acc;
	logic resp;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_data;
	logic wr_ctrl;
	logic rd_stat;
	logic wr_data;
	logic rd_data;

	// one wait state so that read data leaves a flip-flop
	assign resp     = psel & penable & ~pready_reg;
	assign acc      = psel & penable & pready_reg;
	assign sel_ctrl = (paddr == ADDR_W'(SPMSP_CTRL_ADDR));
	assign sel_stat = (paddr == ADDR_W'(SPMSP_STAT_ADDR));
	assign sel_data = (paddr == ADDR_W'(SPMSP_DATA_ADDR));
	assign wr_ctrl  = acc & pwrite & sel_ctrl;
	assign rd_stat  = acc & ~pwrite & sel_stat;
	assign wr_data  = acc & pwrite & sel_data;
	assign rd_data  = acc & ~pwrite & sel_data;

	// ------------------------------------------------------------
	// transfer control
	// ------------------------------------------------------------
	logic fault;
	logic inhibit;
	logic collide;
	logic load;
	logic start;
	logic edge_ev;
	logic lead;
	logic done;
	logic din;
	logic [7:0] shift_in;
	logic samp_ev;
	logic fin;
	logic [7:0] mrx_next;

	assign fault   = master_reg & port_en_reg & ~ss_n_s;
	// unread done flag blocks data writes until status has been seen
	assign inhibit = done_reg & ~seen_done_reg;
	assign collide = busy_reg | (mfin_reg != 2'h0) |
		(~master_reg & ~clock_phase_reg & ~ss_n_s);
	assign load    = wr_data & ~inhibit & ~collide;
	assign start   = load & master_reg & port_en_reg & ~fault;
	// slave edges only count while selected
	assign edge_ev = master_reg ? (busy_reg & rif.tick) :
		(port_en_reg & ~ss_n_s & (sck_s ^ sck_d_reg));
	assign lead    = ~edge_cnt_reg[0];
	assign done    = edge_ev & ~lead &
		(edge_cnt_reg == SPMSP_LAST_EDGE);
	assign din     = master_reg ? miso_s : mosi_s;
	assign shift_in = clock_phase_reg ? {shreg_reg[6:0], din} :
		{shreg_reg[6:0], rx_bit_reg};
	assign samp_ev  = edge_ev & (lead ^ clock_phase_reg);
	// a master byte completes two clocks late, once miso has crossed
	// the synchroniser; writes in that tail count as collisions
	assign fin      = master_reg ? mfin_reg[1] : done;
	assign mrx_next = msamp_reg[1] ? {mrx_reg[6:0], miso_s} : mrx_reg;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq_en_reg  <= SPMSP_CTRL_RST[SPMSP_C_IRQ_EN];
			port_en_reg <= SPMSP_CTRL_RST[SPMSP_C_PORT_EN];
			master_reg  <= SPMSP_CTRL_RST[SPMSP_C_MASTER];
			clock_polarity_reg    <= SPMSP_CTRL_RST[SPMSP_C_CLOCK_POLARITY];
			clock_phase_reg    <= SPMSP_CTRL_RST[SPMSP_C_CLOCK_PHASE];
			rate_reg    <= SPMSP_RATE_0;
		end else begin
			if (wr_ctrl) begin
				irq_en_reg  <= pwdata[SPMSP_C_IRQ_EN];
				port_en_reg <= pwdata[SPMSP_C_PORT_EN];
				master_reg  <= pwdata[SPMSP_C_MASTER];
				clock_polarity_reg    <= pwdata[SPMSP_C_CLOCK_POLARITY];
				clock_phase_reg    <= pwdata[SPMSP_C_CLOCK_PHASE];
				rate_reg    <= spmsp_rate_t'({pwdata[SPMSP_C_RATE_HI],
					pwdata[SPMSP_C_RATE_LO]});
			end
			// a second master on the line wins over software
			if (fault) begin
				master_reg  <= 1'b0;
				port_en_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// status flags; hardware set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			done_reg      <= 1'b0;
			seen_done_reg <= 1'b0;
		end else begin
			done_reg <= fin |
				(done_reg & ~((wr_data | rd_data) & seen_done_reg));
			if (fin || !done_reg)
				seen_done_reg <= 1'b0;
			else if (rd_stat)
				seen_done_reg <= 1'b1;
			else if (wr_data || rd_data)
				seen_done_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			write_collision_flag_reg      <= 1'b0;
			seen_write_collision_flag_reg <= 1'b0;
		end else begin
			write_collision_flag_reg <= (wr_data & ~inhibit & collide) |
				(write_collision_flag_reg & ~((wr_data | rd_data) & seen_write_collision_flag_reg));
			if (rd_stat && write_collision_flag_reg)
				seen_write_collision_flag_reg <= 1'b1;
			else if (wr_data || rd_data)
				seen_write_collision_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mode_fault_flag_reg      <= 1'b0;
			seen_mode_fault_flag_reg <= 1'b0;
		end else begin
			mode_fault_flag_reg <= fault |
				(mode_fault_flag_reg & ~(wr_ctrl & seen_mode_fault_flag_reg));
			if (rd_stat && mode_fault_flag_reg)
				seen_mode_fault_flag_reg <= 1'b1;
			else if (wr_ctrl)
				seen_mode_fault_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// byte sequencing
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busy_reg     <= 1'b0;
			edge_cnt_reg <= 4'h0;
		end else if (!port_en_reg || fault ||
				(!master_reg && ss_n_s) || done) begin
			// deselect aborts a partial slave byte
			busy_reg     <= 1'b0;
			edge_cnt_reg <= 4'h0;
		end else begin
			if (start || edge_ev)
				busy_reg <= 1'b1;
			if (edge_ev)
				edge_cnt_reg <= edge_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			sck_d_reg <= 1'b0;
		else
			sck_d_reg <= sck_s;
	end

	// ------------------------------------------------------------
	// shift register, read buffer and driven bit
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shreg_reg  <= SPMSP_BYTE_RST;
			rx_bit_reg <= 1'b0;
		end else if (load) begin
			shreg_reg <= pwdata[7:0];
		end else if (fin && master_reg) begin
			shreg_reg <= mrx_next;
		end else if (edge_ev) begin
			// phase zero samples on the first edge of each pair
			if (lead && !clock_phase_reg)
				rx_bit_reg <= din;
			if (!lead)
				shreg_reg <= shift_in;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			rdbuf_reg <= SPMSP_BYTE_RST;
		else if (fin)
			rdbuf_reg <= master_reg ? mrx_next : shift_in;
	end

	// ------------------------------------------------------------
	// master receive, aligned to the miso synchroniser
	// ------------------------------------------------------------
	// miso answers our own sck; sampled at the edge itself it would still
	// show the previous bit at fast rates, so it is taken two clocks on
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			msamp_reg <= 2'h0;
			mfin_reg  <= 2'h0;
			mrx_reg   <= SPMSP_BYTE_RST;
		end else begin
			msamp_reg <= {msamp_reg[0], samp_ev & master_reg};
			mfin_reg  <= {mfin_reg[0], done & master_reg};
			mrx_reg   <= mrx_next;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_bit_reg <= 1'b0;
		end else if (load && !clock_phase_reg) begin
			out_bit_reg <= pwdata[7];
		end else if (edge_ev) begin
			if (lead && clock_phase_reg)
				out_bit_reg <= shreg_reg[7];
			else if (!lead && !clock_phase_reg)
				out_bit_reg <= shreg_reg[6];
		end else if (!busy_reg && !clock_phase_reg) begin
			// phase zero slave shows its msb as soon as selected
			out_bit_reg <= shreg_reg[7];
		end
	end

	// ------------------------------------------------------------
	// serial clock generation
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			sck_reg <= 1'b0;
		else if (master_reg && busy_reg)
			sck_reg <= rif.tick ? ~sck_reg : sck_reg;
		else
			sck_reg <= clock_polarity_reg;
	end

	// ------------------------------------------------------------
	// pin enables and system outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sck_oe_n_reg    <= 1'b1;
			mosi_oe_n_reg   <= 1'b1;
			miso_oe_n_reg   <= 1'b1;
			pins_active_reg <= 1'b0;
		end else begin
			sck_oe_n_reg    <= ~(master_reg & port_en_reg);
			mosi_oe_n_reg   <= ~(master_reg & port_en_reg);
			miso_oe_n_reg   <= ~(~master_reg & port_en_reg &
				~ss_n_s);
			pins_active_reg <= port_en_reg;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			irq_reg <= 1'b0;
		else
			irq_reg <= done_reg & irq_en_reg;
	end

	// ------------------------------------------------------------
	// apb answer
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= resp;
			pslverr_reg <= resp & ~(sel_ctrl | sel_stat | sel_data);
			if (resp && !pwrite) begin
				if (sel_ctrl)
					prdata_reg <= {24'h00_0000, irq_en_reg,
						port_en_reg, 1'b0, master_reg, clock_polarity_reg,
						clock_phase_reg, rate_reg};
				else if (sel_stat)
					prdata_reg <= {24'h00_0000, done_reg, write_collision_flag_reg,
						1'b0, mode_fault_flag_reg, 4'h0};
				else if (sel_data)
					prdata_reg <= {24'h00_0000, rdbuf_reg};
				else
					prdata_reg <= 32'h0000_0000;
			end
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign sck_out     = sck_reg;
	assign sck_oe_n    = sck_oe_n_reg;
	assign mosi_out    = out_bit_reg;
	assign mosi_oe_n   = mosi_oe_n_reg;
	assign miso_out    = out_bit_reg;
	assign miso_oe_n   = miso_oe_n_reg;
	assign irq         = irq_reg;
	assign pins_active = pins_active_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	AST_MISO_RELEASE:
	assert property (ss_n_s |=> miso_oe_n)
	else $error("miso driven while unselected");

	AST_MODE_FAULT:
	assert property (fault |=> (!master_reg && !port_en_reg && mode_fault_flag_reg))
	else $error("mode fault not taken");

	AST_EIGHT_PULSES:
	assert property (done |-> edge_cnt_reg == SPMSP_LAST_EDGE && !lead)
	else $error("byte ended on wrong edge count");

	AST_READ_BUFFER:
	assert property (fin |=> rdbuf_reg == shreg_reg && done_reg)
	else $error("read buffer or done flag not updated");

	AST_IRQ_GATE:
	assert property (##1 irq == $past(done_reg & irq_en_reg))
	else $error("interrupt does not follow flag and enable");

	AST_SLAVE_BLOCK:
	assert property ((wr_data && !inhibit && !master_reg && !clock_phase_reg &&
		!ss_n_s) |=> write_collision_flag_reg && $stable(shreg_reg))
	else $error("slave data write not blocked");

	AST_IGNORE_CLOCK:
	assert property ((!master_reg && ss_n_s) |=> edge_cnt_reg == 4'h0)
	else $error("unselected slave counted an edge");

	AST_MASTER_START:
	assert property (start |=> busy_reg && shreg_reg == $past(pwdata[7:0]))
	else $error("master write did not start a byte");

	AST_IDLE_LEVEL:
	assert property ((master_reg && !busy_reg) |=> sck_out == $past(clock_polarity_reg))
	else $error("master idle clock level wrong");

	AST_DONE_PULSE_ONCE:
	assert property (done |=> !done)
	else $error("done asserted twice in a row");
endmodule

// *** inc/spmsp_pkg.sv ***
package spmsp_pkg;

	// ------------------------------------------------------------
	// register map: printed offsets are word indices
	// ------------------------------------------------------------
	localparam int          SPMSP_ADDR_W    = 8;
	localparam logic [7:0]  SPMSP_CTRL_IDX  = 8'h2a;
	localparam logic [7:0]  SPMSP_STAT_IDX  = 8'h2b;
	localparam logic [7:0]  SPMSP_DATA_IDX  = 8'h2c;
	localparam logic [7:0]  SPMSP_CTRL_ADDR = {SPMSP_CTRL_IDX[5:0], 2'b00};
	localparam logic [7:0]  SPMSP_STAT_ADDR = {SPMSP_STAT_IDX[5:0], 2'b00};
	localparam logic [7:0]  SPMSP_DATA_ADDR = {SPMSP_DATA_IDX[5:0], 2'b00};

	// ------------------------------------------------------------
	// control field positions
	// ------------------------------------------------------------
	localparam int SPMSP_C_IRQ_EN  = 7;
	localparam int SPMSP_C_PORT_EN = 6;
	localparam int SPMSP_C_MASTER  = 4;
	localparam int SPMSP_C_CLOCK_POLARITY    = 3;
	localparam int SPMSP_C_CLOCK_PHASE    = 2;
	localparam int SPMSP_C_RATE_HI = 1;
	localparam int SPMSP_C_RATE_LO = 0;

	// ------------------------------------------------------------
	// status field positions
	// ------------------------------------------------------------
	localparam int SPMSP_S_DONE  = 7;
	localparam int SPMSP_S_WRITE_COLLISION_FLAG  = 6;
	localparam int SPMSP_S_MODE_FAULT_FLAG  = 4;

	localparam logic [7:0] SPMSP_CTRL_RST = 8'h00;
	localparam logic [7:0] SPMSP_BYTE_RST = 8'h00;

	// ------------------------------------------------------------
	// serial timing
	// ------------------------------------------------------------
	localparam int         SPMSP_DIV_0     = 2;
	localparam int         SPMSP_DIV_1     = 4;
	localparam int         SPMSP_DIV_2     = 16;
	localparam int         SPMSP_DIV_3     = 32;
	localparam int         SPMSP_BITS      = 8;
	localparam logic [3:0] SPMSP_LAST_EDGE = 4'(2 * SPMSP_BITS - 1);

	typedef enum logic [1:0] {
		SPMSP_RATE_0,
		SPMSP_RATE_1,
		SPMSP_RATE_2,
		SPMSP_RATE_3
	} spmsp_rate_t;

endpackage

// *** inc/spmsp_rate_if.sv ***
`timescale 1ns/100ps
interface spmsp_rate_if;
	logic        run;
	spmsp_pkg::spmsp_rate_t rate;
	logic        tick;

	modport gen (
		input  run,
		input  rate,
		output tick
	);
	modport user (
		output run,
		output rate,
		input  tick
	);
endinterface

// *** verification/spmsp_peer.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// far-side slave: shifts tx out on miso, collects mosi into rx
// ------------------------------------------------------------
module spmsp_peer (
	// serial lines
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	output logic            miso,
	// mode and data
	input  wire logic       clock_polarity,
	input  wire logic       clock_phase,
	input  wire logic [7:0] tx,
	output logic      [7:0] rx
);
	int d;

	initial begin
		d = 0;
		miso = 1'b0;
		rx = 8'h00;
	end

	// released line: show the inverse so a stale bit never passes
	always @(posedge sel_n) miso = ~miso;

	always @(negedge sel_n) begin
		d = 0;
		if (!clock_phase) miso = tx[7];
	end

	always @(sck) begin
		if (!sel_n) begin
			if ((sck != clock_polarity) ^ clock_phase) begin
				rx = {rx[6:0], mosi};
			end else if (d < 8) begin
				// drive one half cycle ahead of the sampling edge
				if (clock_phase) begin
					miso = tx[7 - d];
					d = d + 1;
				end else begin
					d = d + 1;
					miso = (d < 8) ? tx[7 - d] : ~miso;
				end
			end
		end
	end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	import spmsp_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, peer_tx, peer_rx;
	logic [31:0] pwdata, prdata;
	logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, irq;
	logic        miso_out, miso_oe_n, pins_active, peer_miso;
	logic        sck_tb, mosi_tb, ss_n, sel_n, clock_polarity, clock_phase, sck_q;
	logic        sck_w, mosi_w, miso_w;
	int          err_count, total_checks, cyc, edges, run, gap;

	// each line carries whoever has its drive enabled
	assign sck_w  = sck_oe_n  ? sck_tb    : sck_out;
	assign mosi_w = mosi_oe_n ? mosi_tb   : mosi_out;
	assign miso_w = miso_oe_n ? peer_miso : miso_out;

	spmsp_top spmsp_top_i (
		.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
		.mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
		.miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
		.ss_n_in(ss_n), .irq(irq), .pins_active(pins_active)
	);

	spmsp_peer spmsp_peer_i (
		.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n), .miso(peer_miso),
		.clock_polarity(clock_polarity), .clock_phase(clock_phase), .tx(peer_tx), .rx(peer_rx)
	);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ------------------------------------------------------------
	// serial clock monitor and hang guard
	// ------------------------------------------------------------
	always @(posedge clock) begin
		cyc <= cyc + 1;
		sck_q <= sck_out;
		run <= (sck_q !== sck_out) ? 1 : run + 1;
		if (sck_q !== sck_out) begin
			edges <= edges + 1;
			gap <= run;
		end
		if (cyc == 30000) begin
			err_count = err_count + 1;
			results();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic results;
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		total_checks = total_checks + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic e);
		int k;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k = k + 1;
		end while (pready !== 1'b1 && k < 100);
		chk("pready", 1'b1, pready);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input string n, input logic [7:0] a,
		input logic [7:0] x);
		logic [7:0] q;
		logic e;
		apb(1'b0, a, 8'h00, q, e);
		chk(n, x, q);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] q;
		logic e;
		chk("sck_oe_n", 1'b1, sck_oe_n);
		chk("mosi_oe_n", 1'b1, mosi_oe_n);
		chk("miso_oe_n", 1'b1, miso_oe_n);
		chk("pins_active", 1'b0, pins_active);
		rd("ctrl", SPMSP_CTRL_ADDR, 8'h00);
		rd("status", SPMSP_STAT_ADDR, 8'h00);
		apb(1'b0, 8'h00, 8'h00, q, e);
		chk("unmapped_err", 1'b1, e);
	endtask

	task automatic t_master(input int i);
		int e0, k;
		int hp[4] = '{SPMSP_DIV_0/2, SPMSP_DIV_1/2, SPMSP_DIV_2/2,
			SPMSP_DIV_3/2};
		logic [7:0] tx;
		tx = 8'ha5 ^ 8'(i * 8'h33);
		clock_polarity <= i[1];
		clock_phase <= i[0];
		peer_tx <= 8'h5a + 8'(i);
		wr(SPMSP_CTRL_ADDR, {4'hd, i[1], i[0], i[1:0]});
		repeat (2) @(posedge clock);
		chk("sck_idle", i[1], sck_out);
		chk("sck_oe_n", 1'b0, sck_oe_n);
		chk("pins_active", 1'b1, pins_active);
		chk("mosi_oe_n", 1'b0, mosi_oe_n);
		sel_n <= 1'b0;
		@(posedge clock);
		e0 = edges;
		wr(SPMSP_DATA_ADDR, tx);
		k = 0;
		while (irq !== 1'b1 && k < 2000) begin
			@(posedge clock);
			k = k + 1;
		end
		chk("irq", 1'b1, irq);
		chk("sck_edges", 8'h10, 8'(edges - e0));
		chk("half_period", 8'(hp[i]), 8'(gap));
		chk("peer_rx", tx, peer_rx);
		chk("sck_idle", i[1], sck_out);
		sel_n <= 1'b1;
		rd("status", SPMSP_STAT_ADDR, 8'h80);
		rd("data", SPMSP_DATA_ADDR, 8'h5a + 8'(i));
		repeat (2) @(posedge clock);
		chk("irq", 1'b0, irq);
	endtask

	task automatic t_fault;
		wr(SPMSP_CTRL_ADDR, 8'h50);
		ss_n <= 1'b0;
		repeat (6) @(posedge clock);
		ss_n <= 1'b1;
		rd("status", SPMSP_STAT_ADDR, 8'h10);
		rd("ctrl", SPMSP_CTRL_ADDR, 8'h00);
		chk("sck_oe_n", 1'b1, sck_oe_n);
	endtask

	task automatic t_slave;
		logic [7:0] m, got;
		m = 8'hc3;
		got = 8'h00;
		wr(SPMSP_CTRL_ADDR, 8'h47);
		chk("miso_oe_n", 1'b1, miso_oe_n);
		// stray clocks while unselected must not shift anything
		repeat (3) begin
			sck_tb <= 1'b1;
			mosi_tb <= 1'b1;
			repeat (4) @(posedge clock);
			sck_tb <= 1'b0;
			repeat (4) @(posedge clock);
		end
		wr(SPMSP_DATA_ADDR, 8'h3c);
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		chk("miso_oe_n", 1'b0, miso_oe_n);
		for (int b = 7; b >= 0; b--) begin
			sck_tb <= 1'b1;
			mosi_tb <= m[b];
			repeat (4) @(posedge clock);
			got = {got[6:0], miso_w};
			sck_tb <= 1'b0;
			repeat (4) @(posedge clock);
		end
		chk("slave_tx", 8'h3c, got);
		ss_n <= 1'b1;
		repeat (4) @(posedge clock);
		chk("miso_oe_n", 1'b1, miso_oe_n);
		chk("irq_masked", 1'b0, irq);
		rd("status", SPMSP_STAT_ADDR, 8'h80);
		rd("data", SPMSP_DATA_ADDR, m);
	endtask

	task automatic t_collide;
		wr(SPMSP_CTRL_ADDR, 8'h40);
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		wr(SPMSP_DATA_ADDR, 8'h77);
		rd("status", SPMSP_STAT_ADDR, 8'h40);
		ss_n <= 1'b1;
	endtask

	initial begin
		nrst = 1'b0;
		{psel, penable, pwrite, sck_tb, mosi_tb, clock_polarity, clock_phase} = 7'h00;
		{ss_n, sel_n} = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		peer_tx = 8'h00;
		{err_count, total_checks, cyc, edges, run, gap} = 0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		t_reset();
		for (int i = 0; i < 4; i++) t_master(i);
		t_fault();
		t_slave();
		t_collide();
		results();
	end
endmodule
